// file: hw/rpsc_pkg.sv
// constants, field positions and state codes of the root hub port status block
// assumes a 20 MHz controller clock and one status word per downstream port
package rpsc_pkg;

    // =====================================================================
    // map
    localparam int NPORT = 2;
    localparam logic [7:0] PORT_BASE_OFS = 8'h54;
    localparam logic [7:0] PORT_STRIDE = 8'h04;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    // =====================================================================
    // field positions; on write the low bits are port commands
    localparam int B_CURRENT_CONNECT = 0;
    localparam int B_PORT_ENABLED = 1;
    localparam int B_PORT_SUSPENDED = 2;
    localparam int B_PORT_OVERCURRENT = 3;
    localparam int B_PORT_RESET_ACTIVE = 4;
    localparam int B_PORT_POWER_ON = 8;
    localparam int B_SLOW_DEVICE_ATTACHED = 9;
    localparam int B_CONNECT_CHANGE = 16;
    localparam int B_ENABLE_CHANGE = 17;
    localparam int B_SUSPEND_CHANGE = 18;
    localparam int B_OVERCURRENT_CHANGE = 19;
    localparam int B_RESET_DONE_CHANGE = 20;
    localparam int W_CLR_EN = 0;
    localparam int W_SET_EN = 1;
    localparam int W_SET_SUSP = 2;
    localparam int W_CLR_SUSP = 3;
    localparam int W_SET_RST = 4;
    localparam int W_SET_PWR = 8;
    localparam int W_CLR_PWR = 9;
    localparam int CMD_W = 10;
    localparam logic [CMD_W-1:0] CMD_MASK = 10'h31f;

    // =====================================================================
    // timing
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam int RESET_TIME_MS = 10;
    localparam int RESUME_TIME_MS = 20;
    localparam int RESYNC_TIME_MS = 3;
    localparam int EOP_TIME_NS = 1334;
    localparam int RESET_CYC = RESET_TIME_MS * (CLK_HZ / 1000);
    localparam int RESUME_CYC = RESUME_TIME_MS * (CLK_HZ / 1000);
    localparam int RESYNC_CYC = RESYNC_TIME_MS * (CLK_HZ / 1000);
    localparam int EOP_CYC = (EOP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W = 19;
    localparam logic [TMR_W-1:0] TMR_ZERO = 19'h00000;
    localparam logic [TMR_W-1:0] TMR_ONE = 19'h00001;

    // =====================================================================
    // per-port signalling sequence
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RESET = 5'h02,
        ST_RESUME = 5'h04,
        ST_EOP = 5'h08,
        ST_RESYNC = 5'h10
    } rpsc_state_e;

endpackage

// file: hw/rpsc_sync.sv
// three-stage synchroniser for pins from outside the clock domain
// assumes the pin is a slow level; output moves once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module rpsc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_q;

    always_comb begin
        for (int i = 0; i < W; i++) begin
            next_q[i] = (s2[i] == s3[i]) ? s3[i] : q[i];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q <= '0;
        end else if (ce) begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            q <= next_q;
        end
    end
endmodule
`default_nettype wire

// file: hw/rpsc_top.sv
// root hub per-port status and change flags, one word per downstream port
// assumes a single-cycle register strobe port on clk and async port pins
`timescale 1ns/100ps
`default_nettype none
module rpsc_top
    import rpsc_pkg::*;
#(
    parameter int unsigned RESET_CYCLES = RESET_CYC,
    parameter int unsigned RESUME_CYCLES = RESUME_CYC,
    parameter int unsigned RESYNC_CYCLES = RESYNC_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWData,
    output logic [31:0] regRData,
    output logic regRdValid,
    input wire logic [NPORT-1:0] connectPin,
    input wire logic [NPORT-1:0] lowSpeedPin,
    input wire logic [NPORT-1:0] overcurrentPin,
    input wire logic [NPORT-1:0] xferBusy,
    output logic [NPORT-1:0] resetDrive,
    output logic [NPORT-1:0] resumeDrive,
    output logic [NPORT-1:0] eopDrive,
    output logic [NPORT-1:0] powerOn
);

    // =====================================================================
    // helpers
    function automatic logic portHit(input logic [7:0] a, input int p);
        portHit = (a == 8'(PORT_BASE_OFS + PORT_STRIDE * 8'(p)));
    endfunction

    function automatic logic tmrDone(input logic [TMR_W-1:0] t, input int unsigned n);
        tmrDone = (t >= TMR_W'(n - 1));
    endfunction

    // =====================================================================
    // pin synchronisers
    logic [NPORT-1:0] conn;
    logic [NPORT-1:0] slow;
    logic [NPORT-1:0] oc;

    rpsc_sync #(.W(3 * NPORT)) u_sync (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .pin({connectPin, lowSpeedPin, overcurrentPin}),
        .q({conn, slow, oc})
    );

    // =====================================================================
    // port state
    logic [NPORT-1:0] currentConnect, portEnabled, portSuspended, portOvercurrent;
    logic [NPORT-1:0] portResetActive, portPowerOn, slowDeviceAttached;
    logic [NPORT-1:0] connectChange, enableChange, suspendChange, overcurrentChange;
    logic [NPORT-1:0] resetDoneChange;
    logic [NPORT-1:0] pend;
    logic [CMD_W-1:0] pendCmd [NPORT];
    logic [TMR_W-1:0] tmr [NPORT];
    rpsc_state_e st [NPORT];

    logic [NPORT-1:0] next_currentConnect, next_portEnabled, next_portSuspended;
    logic [NPORT-1:0] next_portOvercurrent, next_portResetActive, next_portPowerOn;
    logic [NPORT-1:0] next_slowDeviceAttached;
    logic [NPORT-1:0] next_connectChange, next_enableChange, next_suspendChange;
    logic [NPORT-1:0] next_overcurrentChange, next_resetDoneChange;
    logic [NPORT-1:0] next_pend;
    logic [CMD_W-1:0] next_pendCmd [NPORT];
    logic [TMR_W-1:0] next_tmr [NPORT];
    rpsc_state_e next_st [NPORT];
    logic [NPORT-1:0] next_resetDrive, next_resumeDrive, next_eopDrive;

    always_comb begin
        logic wrHit;
        logic connectNow;
        logic [CMD_W-1:0] newCmd;
        logic [CMD_W-1:0] cmd;
        logic [31:0] clr;
        wrHit = 1'b0;
        connectNow = 1'b0;
        newCmd = '0;
        cmd = '0;
        clr = '0;
        for (int p = 0; p < NPORT; p++) begin
            wrHit = regWr && portHit(regAddr, p);
            // reserved bits 31..21 never indexed; flags of the other port untouched
            clr = wrHit ? regWData : '0;
            newCmd = wrHit ? (regWData[CMD_W-1:0] & CMD_MASK) : '0;

            // write-one-to-clear first, so a same-cycle hardware set wins
            next_connectChange[p] = connectChange[p] & ~clr[B_CONNECT_CHANGE];
            next_enableChange[p] = enableChange[p] & ~clr[B_ENABLE_CHANGE];
            next_suspendChange[p] = suspendChange[p] & ~clr[B_SUSPEND_CHANGE];
            next_overcurrentChange[p] = overcurrentChange[p] & ~clr[B_OVERCURRENT_CHANGE];
            next_resetDoneChange[p] = resetDoneChange[p] & ~clr[B_RESET_DONE_CHANGE];
            next_currentConnect[p] = currentConnect[p];
            next_portEnabled[p] = portEnabled[p];
            next_portSuspended[p] = portSuspended[p];
            next_portOvercurrent[p] = portOvercurrent[p];
            next_portResetActive[p] = portResetActive[p];
            next_portPowerOn[p] = portPowerOn[p];
            next_slowDeviceAttached[p] = slowDeviceAttached[p];
            next_st[p] = st[p];
            next_tmr[p] = tmr[p];

            // port commands wait for the current transfer to finish
            if (xferBusy[p]) begin
                next_pend[p] = pend[p] | (newCmd != '0);
                next_pendCmd[p] = pendCmd[p] | newCmd;
                cmd = '0;
            end else begin
                next_pend[p] = 1'b0;
                next_pendCmd[p] = '0;
                cmd = pendCmd[p] | newCmd;
            end

            // attach and detach
            connectNow = conn[p] & portPowerOn[p];
            next_currentConnect[p] = connectNow;
            next_slowDeviceAttached[p] = connectNow & slow[p];
            if (connectNow != currentConnect[p]) begin
                next_connectChange[p] = 1'b1;
            end
            if (!connectNow && portEnabled[p]) begin
                next_portEnabled[p] = 1'b0;
                next_enableChange[p] = 1'b1;
            end
            if (!connectNow) begin
                next_portSuspended[p] = 1'b0;
            end

            // overcurrent tracked per port
            next_portOvercurrent[p] = oc[p];
            if (oc[p] != portOvercurrent[p]) begin
                next_overcurrentChange[p] = 1'b1;
            end
            if (oc[p] && portEnabled[p]) begin
                next_portEnabled[p] = 1'b0;
                next_enableChange[p] = 1'b1;
            end

            // software commands: enable changes here never touch enableChange
            if (cmd[W_CLR_EN]) begin
                next_portEnabled[p] = 1'b0;
            end
            if (cmd[W_SET_EN]) begin
                if (currentConnect[p]) begin
                    next_portEnabled[p] = 1'b1;
                end else begin
                    next_connectChange[p] = 1'b1;
                end
            end
            if (cmd[W_SET_SUSP]) begin
                if (!currentConnect[p]) begin
                    next_connectChange[p] = 1'b1;
                end else if (portEnabled[p]) begin
                    next_portSuspended[p] = 1'b1;
                end
            end
            if (cmd[W_CLR_SUSP] && portSuspended[p] && st[p] == ST_IDLE) begin
                next_st[p] = ST_RESUME;
                next_tmr[p] = TMR_ZERO;
            end
            if (cmd[W_SET_RST]) begin
                if (!currentConnect[p]) begin
                    next_connectChange[p] = 1'b1;
                end else if (st[p] == ST_IDLE) begin
                    next_st[p] = ST_RESET;
                    next_portResetActive[p] = 1'b1;
                    next_tmr[p] = TMR_ZERO;
                end
            end
            if (cmd[W_SET_PWR]) begin
                next_portPowerOn[p] = 1'b1;
            end
            if (cmd[W_CLR_PWR]) begin
                next_portPowerOn[p] = 1'b0;
                next_portEnabled[p] = 1'b0;
                next_portSuspended[p] = 1'b0;
            end

            // reset and resume signalling
            unique case (st[p])
                ST_IDLE: begin
                end
                ST_RESET: begin
                    next_tmr[p] = tmr[p] + TMR_ONE;
                    if (tmrDone(tmr[p], RESET_CYCLES)) begin
                        next_st[p] = ST_IDLE;
                        next_portResetActive[p] = 1'b0;
                        next_portEnabled[p] = connectNow;
                        next_resetDoneChange[p] = 1'b1;
                        next_suspendChange[p] = 1'b0;
                    end
                end
                ST_RESUME: begin
                    next_tmr[p] = tmr[p] + TMR_ONE;
                    if (tmrDone(tmr[p], RESUME_CYCLES)) begin
                        next_st[p] = ST_EOP;
                        next_tmr[p] = TMR_ZERO;
                    end
                end
                ST_EOP: begin
                    next_tmr[p] = tmr[p] + TMR_ONE;
                    if (tmrDone(tmr[p], EOP_CYC)) begin
                        next_st[p] = ST_RESYNC;
                        next_tmr[p] = TMR_ZERO;
                    end
                end
                ST_RESYNC: begin
                    next_tmr[p] = tmr[p] + TMR_ONE;
                    if (tmrDone(tmr[p], RESYNC_CYCLES)) begin
                        next_st[p] = ST_IDLE;
                        next_portSuspended[p] = 1'b0;
                        next_suspendChange[p] = 1'b1;
                    end
                end
                default: begin
                    next_st[p] = ST_IDLE;
                    next_portResetActive[p] = 1'b0;
                end
            endcase
            // detach or power-off aborts signalling under way; a reset or resume started in the same cycle still drives for one cycle
            if (!(connectNow && next_portPowerOn[p]) && st[p] != ST_IDLE) begin
                next_st[p] = ST_IDLE;
                next_portResetActive[p] = 1'b0;
            end
            next_resetDrive[p] = (next_st[p] == ST_RESET);
            next_resumeDrive[p] = (next_st[p] == ST_RESUME);
            next_eopDrive[p] = (next_st[p] == ST_EOP);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {currentConnect, portEnabled, portSuspended, portOvercurrent} <= '0;
            {portResetActive, portPowerOn, slowDeviceAttached} <= '0;
            {connectChange, enableChange, suspendChange} <= '0;
            {overcurrentChange, resetDoneChange} <= '0;
            pend <= '0;
            resetDrive <= '0;
            resumeDrive <= '0;
            eopDrive <= '0;
            powerOn <= '0;
            for (int p = 0; p < NPORT; p++) begin
                pendCmd[p] <= '0;
                tmr[p] <= TMR_ZERO;
                st[p] <= ST_IDLE;
            end
        end else if (ce) begin
            currentConnect <= next_currentConnect;
            portEnabled <= next_portEnabled;
            portSuspended <= next_portSuspended;
            portOvercurrent <= next_portOvercurrent;
            portResetActive <= next_portResetActive;
            portPowerOn <= next_portPowerOn;
            slowDeviceAttached <= next_slowDeviceAttached;
            connectChange <= next_connectChange;
            enableChange <= next_enableChange;
            suspendChange <= next_suspendChange;
            overcurrentChange <= next_overcurrentChange;
            resetDoneChange <= next_resetDoneChange;
            pend <= next_pend;
            resetDrive <= next_resetDrive;
            resumeDrive <= next_resumeDrive;
            eopDrive <= next_eopDrive;
            powerOn <= next_portPowerOn;
            for (int p = 0; p < NPORT; p++) begin
                pendCmd[p] <= next_pendCmd[p];
                tmr[p] <= next_tmr[p];
                st[p] <= next_st[p];
            end
        end
    end

    // =====================================================================
    // read path: one word per port, unmapped reads return zero
    logic [31:0] next_regRData;
    logic next_regRdValid;

    always_comb begin
        next_regRData = REG_RESET;
        next_regRdValid = regRd;
        for (int p = 0; p < NPORT; p++) begin
            if (regRd && portHit(regAddr, p)) begin
                next_regRData[B_CURRENT_CONNECT] = currentConnect[p];
                next_regRData[B_PORT_ENABLED] = portEnabled[p];
                next_regRData[B_PORT_SUSPENDED] = portSuspended[p];
                next_regRData[B_PORT_OVERCURRENT] = portOvercurrent[p];
                next_regRData[B_PORT_RESET_ACTIVE] = portResetActive[p];
                next_regRData[B_PORT_POWER_ON] = portPowerOn[p];
                next_regRData[B_SLOW_DEVICE_ATTACHED] = slowDeviceAttached[p];
                next_regRData[B_CONNECT_CHANGE] = connectChange[p];
                next_regRData[B_ENABLE_CHANGE] = enableChange[p];
                next_regRData[B_SUSPEND_CHANGE] = suspendChange[p];
                next_regRData[B_OVERCURRENT_CHANGE] = overcurrentChange[p];
                next_regRData[B_RESET_DONE_CHANGE] = resetDoneChange[p];
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            regRData <= REG_RESET;
            regRdValid <= 1'b0;
        end else if (ce) begin
            regRData <= next_regRData;
            regRdValid <= next_regRdValid;
        end
    end

endmodule
`default_nettype wire

// file: sim/rpsc_monitor.sv
// checker for the root hub port status block, watching port zero
// assumes a bind to rpsc_top; ce is held high by the bench
`timescale 1ns/100ps
`default_nettype none
module rpsc_monitor
    import rpsc_pkg::*;
#(
    parameter int unsigned RESET_CYCLES = RESET_CYC,
    parameter int unsigned RESUME_CYCLES = RESUME_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWData,
    input wire logic [31:0] regRData,
    input wire logic regRdValid,
    input wire logic [NPORT-1:0] connectPin,
    input wire logic [NPORT-1:0] xferBusy,
    input wire logic [NPORT-1:0] resetDrive,
    input wire logic [NPORT-1:0] resumeDrive,
    input wire logic [NPORT-1:0] eopDrive,
    input wire logic [NPORT-1:0] powerOn
);
    // ==========================================
    // drive lengths; counts restart when the drive drops
    logic [31:0] rstCnt, resCnt, eopCnt, next_rstCnt, next_resCnt, next_eopCnt;
    always_comb begin
        next_rstCnt = resetDrive[0] ? rstCnt + 32'h1 : 32'h0;
        next_resCnt = resumeDrive[0] ? resCnt + 32'h1 : 32'h0;
        next_eopCnt = eopDrive[0] ? eopCnt + 32'h1 : 32'h0;
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rstCnt <= 32'h0;
            resCnt <= 32'h0;
            eopCnt <= 32'h0;
        end else begin
            rstCnt <= next_rstCnt;
            resCnt <= next_resCnt;
            eopCnt <= next_eopCnt;
        end
    end
    // ==========================================
    // properties
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    sequence busyRstWr;
        ce && regWr && regAddr == 8'h54 && regWData[4] && xferBusy[0] && !resetDrive[0];
    endsequence
    chk_rd_answer: assert property (ce && regRd |=> regRdValid)
        else $error("read strobe got no answer");
    chk_rd_single: assert property (regRdValid |-> $past(regRd))
        else $error("read answer without strobe");
    chk_unmapped_zero: assert property (ce && regRd && regAddr != 8'h54 && regAddr != 8'h58
        |=> regRData == 32'h0)
        else $error("unmapped read not zero");
    chk_reserved_zero: assert property (regRdValid |-> (regRData & 32'hffe0_fce0) == 32'h0)
        else $error("reserved bits read nonzero");
    chk_reset_len: assert property ($fell(resetDrive[0]) && connectPin[0] && powerOn[0]
        |-> rstCnt == RESET_CYCLES)
        else $error("reset drive length wrong");
    chk_resume_len: assert property ($fell(resumeDrive[0]) && connectPin[0]
        |-> resCnt == RESUME_CYCLES && eopDrive[0])
        else $error("resume drive length or eop order wrong");
    chk_eop_len: assert property ($fell(eopDrive[0]) && connectPin[0] |-> eopCnt == 27)
        else $error("eop length wrong");
    chk_defer_busy: assert property (busyRstWr ##1 xferBusy[0] |-> !resetDrive[0])
        else $error("port command applied during transfer");
    chk_drive_power: assert property (resetDrive[0] || resumeDrive[0] |-> powerOn[0])
        else $error("signalling on unpowered port");
endmodule
bind rpsc_top rpsc_monitor #(.RESET_CYCLES(RESET_CYCLES), .RESUME_CYCLES(RESUME_CYCLES))
    i_rpsc_monitor (.clk(clk), .nrst(nrst), .ce(ce), .regWr(regWr), .regRd(regRd),
    .regAddr(regAddr), .regWData(regWData), .regRData(regRData), .regRdValid(regRdValid),
    .connectPin(connectPin), .xferBusy(xferBusy), .resetDrive(resetDrive),
    .resumeDrive(resumeDrive), .eopDrive(eopDrive), .powerOn(powerOn));
`default_nettype wire

// file: sim/rpsc_dev_model.sv
// behavioural devices on the two downstream ports
// assumes the bench calls its tasks; pins move just after a rising edge
`timescale 1ns/100ps
`default_nettype none
module rpsc_dev_model
    import rpsc_pkg::*;
(
    input wire logic clk,
    output logic [NPORT-1:0] connectPin,
    output logic [NPORT-1:0] lowSpeedPin,
    output logic [NPORT-1:0] overcurrentPin,
    output logic [NPORT-1:0] xferBusy
);
    // ==========================================
    // pin levels
    initial begin
        connectPin = 2'h0;
        lowSpeedPin = 2'h0;
        overcurrentPin = 2'h0;
        xferBusy = 2'h0;
    end
    // speed level settles with the attach, as a real pull-up does
    task automatic plug(input int p, input logic slow);
        @(posedge clk);
        connectPin[p] <= 1'h1;
        lowSpeedPin[p] <= slow;
    endtask
    task automatic fault(input int p);
        @(posedge clk);
        overcurrentPin[p] <= 1'h1;
    endtask
    // token-to-handshake window seen by the block
    task automatic busy(input int p, input logic b);
        @(posedge clk);
        xferBusy[p] <= b;
    endtask
endmodule
`default_nettype wire

// file: sim/rpsc_top_bench.sv
// self-checking bench for the root hub port status block
// assumes short signalling parameters; ce tied high
`timescale 1ns/100ps
`default_nettype none
module rpsc_top_bench
    import rpsc_pkg::*;
;
    logic clk, nrst, regWr, regRd, regRdValid;
    logic [7:0] regAddr;
    logic [31:0] regWData, regRData, rdv;
    logic [NPORT-1:0] connectPin, lowSpeedPin, overcurrentPin, xferBusy;
    logic [NPORT-1:0] resetDrive, resumeDrive, eopDrive, powerOn;
    int errCount, nTests;
    rpsc_top #(.RESET_CYCLES(20), .RESUME_CYCLES(30), .RESYNC_CYCLES(10)) i_rpsc_top (
        .clk(clk), .nrst(nrst), .ce(1'h1), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
        .regWData(regWData), .regRData(regRData), .regRdValid(regRdValid),
        .connectPin(connectPin), .lowSpeedPin(lowSpeedPin), .overcurrentPin(overcurrentPin),
        .xferBusy(xferBusy), .resetDrive(resetDrive), .resumeDrive(resumeDrive),
        .eopDrive(eopDrive), .powerOn(powerOn));
    rpsc_dev_model i_rpsc_dev_model (.clk(clk), .connectPin(connectPin),
        .lowSpeedPin(lowSpeedPin), .overcurrentPin(overcurrentPin), .xferBusy(xferBusy));
    always #25 clk = ~clk;
    // ==========================================
    // bus and comparison tasks
    task automatic wrapUp();
        $display("comparisons %0d mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            errCount++;
            $display("[FAIL] %0t read %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'h1;
        regAddr <= a;
        regWData <= d;
        @(posedge clk);
        regWr <= 1'h0;
    endtask
    // answer stands one cycle, so it is taken just after the taking edge
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        regRd <= 1'h1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'h0;
        #1;
        rdv = (regRdValid === 1'h1) ? regRData : 32'hxxxx_xxxx;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        check(rdv, exp);
    endtask
    task automatic poll(input logic [7:0] a, input logic [31:0] exp);
        for (int i = 0; i < 200; i++) begin
            rd(a);
            if (rdv === exp) begin
                break;
            end
        end
        check(rdv, exp);
        if (rdv !== exp) begin
            wrapUp();
        end
    endtask
    // ==========================================
    // scenarios
    task automatic tResetVals();
        rdChk(8'h54, 32'h0);
        rdChk(8'h58, 32'h0);
        wr(8'h5c, 32'h0000_0100);
        rdChk(8'h5c, 32'h0);
        rdChk(8'h54, 32'h0);
    endtask
    task automatic tAttach();
        wr(8'h58, 32'h0000_0100);
        wr(8'h58, 32'h0000_0002);
        rdChk(8'h58, 32'h0001_0100);
        wr(8'h54, 32'h0000_0100);
        i_rpsc_dev_model.plug(0, 1'h1);
        i_rpsc_dev_model.plug(1, 1'h0);
        poll(8'h54, 32'h0001_0301);
        poll(8'h58, 32'h0001_0101);
    endtask
    task automatic tClear();
        wr(8'h54, 32'h0001_0000);
        rdChk(8'h54, 32'h0000_0301);
        wr(8'h58, 32'h0000_0000);
        rdChk(8'h58, 32'h0001_0101);
        wr(8'h58, 32'h0001_0000);
        rdChk(8'h58, 32'h0000_0101);
    endtask
    task automatic tResetDefer();
        wr(8'h54, 32'h0000_0010);
        poll(8'h54, 32'h0010_0303);
        i_rpsc_dev_model.busy(0, 1'h1);
        wr(8'h54, 32'h0000_0004);
        repeat (4) @(posedge clk);
        rdChk(8'h54, 32'h0010_0303);
        i_rpsc_dev_model.busy(0, 1'h0);
        poll(8'h54, 32'h0010_0307);
    endtask
    task automatic tResume();
        wr(8'h54, 32'h0000_0008);
        poll(8'h54, 32'h0014_0303);
        wr(8'h54, 32'h0010_0000);
        rdChk(8'h54, 32'h0004_0303);
        i_rpsc_dev_model.busy(0, 1'h1);
        wr(8'h54, 32'h0000_0010);
        rdChk(8'h54, 32'h0004_0303);
        i_rpsc_dev_model.busy(0, 1'h0);
        poll(8'h54, 32'h0010_0303);
    endtask
    task automatic tDisable();
        wr(8'h58, 32'h0000_0002);
        rdChk(8'h58, 32'h0000_0103);
        wr(8'h58, 32'h0000_0001);
        rdChk(8'h58, 32'h0000_0101);
        i_rpsc_dev_model.fault(0);
        poll(8'h54, 32'h001a_0309);
        wr(8'h54, 32'h001a_0000);
        rdChk(8'h54, 32'h0000_0309);
        wr(8'h58, 32'h0000_0200);
        rdChk(8'h58, 32'h0001_0000);
        check(32'(powerOn), 32'h0000_0001);
    endtask
    // ==========================================
    // main sequence
    initial begin
        clk = 1'h0;
        nrst = 1'h0;
        regWr = 1'h0;
        regRd = 1'h0;
        regAddr = 8'h00;
        regWData = 32'h0;
        errCount = 0;
        nTests = 0;
        repeat (5) @(posedge clk);
        nrst <= 1'h1;
        tResetVals();
        tAttach();
        tClear();
        tResetDefer();
        tResume();
        tDisable();
        wrapUp();
    end
endmodule
`default_nettype wire
